/* rtl/r8dp_core.sv */
// decoder, alu, status flags and register bus of the 8-bit processor
// Contract
// RULE1: opcode held; outputs from opcode and cycle
// RULE2: write strobe comes straight from flop
// RULE3: ready low freezes all state updates; the external flag forces still update flag bits seven..four
// RULE4: interrupt or reset injects interrupt-entry opcode
// RULE5: alu works on register or temp operands
// RULE6: constants zero and one selectable operands
// RULE7: test, set, clear one bit
// RULE8: most opcodes update flags through alu
// RULE9: force-high inputs set upper flag bits
// RULE10: force-low inputs clear upper flag bits
// RULE11: flag bit three masks maskable interrupts
// RULE12: negative flag copies result bit seven
// RULE13: carry is not-borrow on subtract
// RULE14: zero flag set when result zero
// RULE15: sixteen bytes, two banks, two reads
// RULE16: one read/write port, one read port
// RULE17: register zero is the accumulator
// RULE18: register pairs four..seven form addresses
// RULE19: mask bit selects the second bank
// RULE20: reset held at least three edges
// RULE21: all flops on rising system clock
// RULE22: read strobe high while loading bus byte
// RULE23: force-high wins over force-low
// RULE24: external force beats instruction update
//
// Implementation choices: the placing of the registers and the Avalon-MM register port.
module r8dp_core #(
  parameter int NUM_INT = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // memory and io bus
  output logic [15:0] mem_addr,
  input wire logic [7:0] bus_read_byte,
  output logic [7:0] data_out,
  output logic read_strobe,
  output logic write_strobe,
  output logic op_fetch,
  input wire logic bus_ready,
  // interrupts and external flags
  input wire logic [NUM_INT-1:0] int_req,
  input wire logic [3:0] flag_force_high,
  input wire logic [3:0] flag_force_low,
  output logic [7:0] processor_status_flags
);
  import r8dp_pkg::*;

  if (NUM_INT < 2 || NUM_INT > 8) begin : g_chk
    $error("NUM_INT must lie between 2 and 8");
  end

  localparam int PW = NUM_INT + 9;

  // ==========================================================
  // reset release and pin synchronisers
  logic rst_meta_q, rst_n_q;
  // RULE21: single rising-edge clock everywhere
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  logic [PW-1:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_f_q;
  logic ready;
  logic [NUM_INT-1:0] int_f;
  logic [3:0] fhi, flo;
  // a pin change counts only once stages two and three agree
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pin_s1_q <= {READY_RST, {(PW-1){1'b0}}};
      pin_s2_q <= {READY_RST, {(PW-1){1'b0}}};
      pin_s3_q <= {READY_RST, {(PW-1){1'b0}}};
      pin_f_q <= {READY_RST, {(PW-1){1'b0}}};
    end else begin
      pin_s1_q <= {bus_ready, int_req, flag_force_high, flag_force_low};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_f_q <= (pin_s2_q & ~(pin_s2_q ^ pin_s3_q)) | (pin_f_q & (pin_s2_q ^ pin_s3_q));
    end
  end
  assign {ready, int_f, fhi, flo} = pin_f_q;

  // ==========================================================
  // state and register file link
  r8dp_state_t state_q;
  logic [1:0] cyc_q;
  logic [7:0] opcode_q, flg_q, flg_d, temp_q, dout_q;
  logic [15:0] pc_q, addr_q, pc_nx;
  logic [3:0] kind_q, kind_pick;
  logic write_q, run_q;
  r8dp_rf_if rf_bus ();

  r8dp_regfile #(.DEPTH(RF_DEPTH)) u_rf (
    .clk_sys(clk_sys),
    .rst_n(rst_n_q),
    .rfp(rf_bus.rf)
  );

  // lowest line wins; line zero ignores the mask
  function automatic logic [3:0] pick_int(input logic [NUM_INT-1:0] req);
    logic [3:0] k;
    k = 4'h0;
    for (int i = NUM_INT - 1; i >= 0; i--) begin
      if (req[i]) k = 4'(i);
    end
    return k;
  endfunction

  // one alu for all data paths, carry out on top
  function automatic logic [8:0] alu_f(input r8dp_alu_t op, input logic [7:0] a,
                                       input logic [7:0] b, input logic cin);
    logic [8:0] r;
    r = {cin, b};
    unique case (op)
      ALU_PASS: r = {cin, b};
      ALU_ADD: r = {1'b0, a} + {1'b0, b};
      ALU_SUB: r = {1'b0, a} + {1'b0, ~b} + 9'h001;
      ALU_AND: r = {cin, a & b};
      ALU_OR: r = {cin, a | b};
      ALU_XOR: r = {cin, a ^ b};
    endcase
    return r;
  endfunction

  // ==========================================================
  // decode: opcode class and cycle count give the controls
  logic [3:0] cls;
  logic [2:0] rn, pr_a, pr_b;
  logic ex, rf_we, flag_we, done, flg_wr, int_pend, go_next;
  logic [7:0] opb, bitmask;
  r8dp_alu_t alu_op;
  logic [8:0] alu_r;

  assign cls = opcode_q[7:4];
  assign rn = opcode_q[2:0];
  assign bitmask = 8'h01 << rn;
  assign ex = (state_q == ST_EXEC);
  // RULE11: mask bit gates all lines but zero
  assign int_pend = int_f[0] | (~flg_q[FLG_I] & (|int_f[NUM_INT-1:1]));
  assign kind_pick = pick_int(int_pend ? (int_f & {{(NUM_INT-1){~flg_q[FLG_I]}}, 1'b1})
                                       : '0);

  // RULE1: controls from opcode and cycle count
  always_comb begin
    pr_a = 3'h0;
    pr_b = rn;
    opb = rf_bus.rdata_b;
    alu_op = ALU_PASS;
    rf_we = 1'b0;
    flag_we = 1'b0;
    flg_wr = 1'b0;
    done = 1'b1;
    unique case (cls)
      CLS_NOP: ;
      // RULE17: accumulator is default destination
      CLS_MOVA: begin rf_we = 1'b1; flag_we = 1'b1; end
      CLS_MOVR: begin pr_a = rn; pr_b = 3'h0; rf_we = 1'b1; flag_we = 1'b1; end
      CLS_ADD: begin alu_op = ALU_ADD; rf_we = 1'b1; flag_we = 1'b1; end
      CLS_SUB: begin alu_op = ALU_SUB; rf_we = 1'b1; flag_we = 1'b1; end
      CLS_AND: begin alu_op = ALU_AND; rf_we = 1'b1; flag_we = 1'b1; end
      CLS_OR: begin alu_op = ALU_OR; rf_we = 1'b1; flag_we = 1'b1; end
      CLS_XOR: begin alu_op = ALU_XOR; rf_we = 1'b1; flag_we = 1'b1; end
      // RULE6: constant one for increment and decrement
      CLS_INC, CLS_DEC: begin
        pr_a = rn;
        opb = 8'h01;
        alu_op = (cls == CLS_INC) ? ALU_ADD : ALU_SUB;
        rf_we = 1'b1;
        flag_we = 1'b1;
      end
      // RULE7: bit test, set and clear
      CLS_BTST: begin opb = bitmask; alu_op = ALU_AND; flag_we = 1'b1; end
      CLS_BSET: begin opb = bitmask; alu_op = ALU_OR; rf_we = 1'b1; flag_we = 1'b1; end
      CLS_BCLR: begin opb = ~bitmask; alu_op = ALU_AND; rf_we = 1'b1; flag_we = 1'b1; end
      // RULE18: pair four/five or six/seven, high byte first
      CLS_LD: begin
        done = (cyc_q == CYC_LAST_LD);
        pr_a = done ? 3'h0 : {1'b1, rn[0], 1'b0};
        pr_b = {1'b1, rn[0], 1'b1};
        opb = bus_read_byte;
        rf_we = done;
        flag_we = done;
      end
      CLS_ST: begin
        done = (cyc_q == CYC_LAST_ST);
        pr_a = {1'b1, rn[0], 1'b0};
        pr_b = (cyc_q == 2'h0) ? {1'b1, rn[0], 1'b1} : 3'h0;
      end
      CLS_SYS: begin
        // RULE5: temp register as second operand
        if (opcode_q == OP_ADDT) begin
          opb = temp_q;
          alu_op = ALU_ADD;
          rf_we = 1'b1;
          flag_we = 1'b1;
        end else if (opcode_q == OP_CLRA) begin
          opb = 8'h00;
          rf_we = 1'b1;
          flag_we = 1'b1;
        end else if (opcode_q == OP_MOVP) begin
          pr_b = 3'h0;
          flg_wr = 1'b1;
        end
      end
    endcase
  end

  // RULE8: result and flags come out of the alu
  assign alu_r = alu_f(alu_op, rf_bus.rdata_a, opb, flg_q[FLG_C]);

  // RULE19: mask bit picks the register bank
  assign rf_bus.idx_a = {flg_q[FLG_I], pr_a};
  assign rf_bus.idx_b = {flg_q[FLG_I], pr_b};
  // RULE3: no register load while frozen
  assign rf_bus.we = rf_we & ex & ready;
  assign rf_bus.wdata = alu_r[7:0];

  // ==========================================================
  // sequencer: idle, fetch, execute
  assign go_next = ((state_q == ST_IDLE) & run_q) | (ex & done);
  always_comb begin
    pc_nx = pc_q;
    if (ex && opcode_q == OP_INT) begin
      pc_nx = (kind_q == KIND_RST) ? PC_RST : {VEC_BASE[15:4], kind_q[2:0], 1'b0};
    end
  end

  // RULE4: reset leaves the entry opcode pending
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= ST_EXEC;
      opcode_q <= OP_INT;
      kind_q <= KIND_RST;
      cyc_q <= 2'h0;
      pc_q <= PC_RST;
      addr_q <= PC_RST;
    end else if (ready) begin
      if (state_q == ST_FETCH) begin
        opcode_q <= bus_read_byte;
        pc_q <= pc_q + 16'h0001;
        state_q <= ST_EXEC;
        cyc_q <= 2'h0;
      end else if (go_next) begin
        pc_q <= pc_nx;
        cyc_q <= 2'h0;
        if (!run_q) begin
          state_q <= ST_IDLE;
        // RULE4: inject entry opcode instead of fetching
        end else if (int_pend) begin
          opcode_q <= OP_INT;
          kind_q <= kind_pick;
          state_q <= ST_EXEC;
        end else begin
          addr_q <= pc_nx;
          state_q <= ST_FETCH;
        end
      end else if (ex) begin
        cyc_q <= cyc_q + 2'h1;
        if ((cls == CLS_LD || cls == CLS_ST) && cyc_q == 2'h0) begin
          addr_q <= {rf_bus.rdata_a, rf_bus.rdata_b};
        end
      end
    end
  end

  // RULE2: strobe and data both from flops, no glitch
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      write_q <= 1'b0;
      dout_q <= 8'h00;
    end else if (ready) begin
      write_q <= ex & (cls == CLS_ST) & (cyc_q == 2'h1);
      if (ex && cls == CLS_ST && cyc_q == 2'h1) begin
        dout_q <= rf_bus.rdata_b;
      end
    end
  end

  // ==========================================================
  // status flags
  always_comb begin
    flg_d = flg_q;
    if (ready && ex) begin
      // RULE12: negative from bit seven
      if (flag_we) flg_d[FLG_N] = alu_r[7];
      // RULE13: carry out, which is not-borrow on subtract
      if (flag_we) flg_d[FLG_C] = alu_r[8];
      // RULE14: zero when result is zero
      if (flag_we) flg_d[FLG_Z] = (alu_r[7:0] == 8'h00);
      if (flg_wr) flg_d = rf_bus.rdata_b;
      if (opcode_q == OP_INT) flg_d = (kind_q == KIND_RST) ? FLG_RST : (flg_q | 8'h08);
      if (opcode_q == OP_RTI) flg_d[FLG_I] = 1'b0;
    end
    // RULE24: external force applied last
    // RULE10: force-low clears the bit
    // RULE9: force-high sets the bit, RULE23 it wins
    flg_d[7:4] = (flg_d[7:4] & ~flo) | fhi;
  end

  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) flg_q <= FLG_RST;
    else flg_q <= flg_d;
  end

  // ==========================================================
  // avalon slave: one wait cycle, then answer
  logic ack_q;
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ack_q <= 1'b0;
      avs_readdata <= 32'h0000_0000;
      run_q <= CTRL_RUN_RST;
      temp_q <= TEMP_RST;
    end else begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
      if (avs_read && !ack_q) begin
        unique case (avs_address)
          OFF_CTRL: avs_readdata <= {31'h0, run_q};
          OFF_STAT: avs_readdata <= {8'h00, ready, state_q, kind_q, opcode_q, flg_q};
          OFF_TEMP: avs_readdata <= {24'h000000, temp_q};
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
      // writes land on the edge where waitrequest is low
      if (avs_write && ack_q && avs_byteenable[0]) begin
        if (avs_address == OFF_CTRL) run_q <= avs_writedata[CTRL_RUN_BIT];
        if (avs_address == OFF_TEMP) temp_q <= avs_writedata[7:0];
      end
    end
  end
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;

  // ==========================================================
  // outputs
  assign mem_addr = addr_q;
  assign data_out = dout_q;
  assign write_strobe = write_q;
  assign op_fetch = (state_q == ST_FETCH);
  // RULE22: read strobe on fetch and the last load cycle
  assign read_strobe = op_fetch | (ex & (cls == CLS_LD) & (cyc_q == CYC_LAST_LD));
  assign processor_status_flags = flg_q;

  // ==========================================================
  // assertions and covers
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n_q);

  // a freeze in the strobe cycle legally stretches the strobe
  property p_wr_strobe;
    ex && cls == CLS_ST && cyc_q == 2'h1 && ready |=> write_strobe
      ##1 (!write_strobe || !$past(ready));
  endproperty
  a_wr_strobe: assert property (p_wr_strobe) // RULE2
    else $error("write strobe not one flop cycle after store data");

  property p_freeze;
    !ready |=> $stable(opcode_q) && $stable(pc_q) && $stable(flg_q[3:0]) && $stable(cyc_q);
  endproperty
  a_freeze: assert property (p_freeze) // RULE3
    else $error("state moved while ready was low");

  property p_rst_inj;
    $rose(rst_n_q) |-> opcode_q == OP_INT && kind_q == KIND_RST && state_q == ST_EXEC;
  endproperty
  a_rst_inj: assert property (p_rst_inj) // RULE4
    else $error("reset did not leave the entry opcode");

  property p_force_hi;
    fhi[3] |=> flg_q[7];
  endproperty
  a_force_hi: assert property (p_force_hi) // RULE9
    else $error("force-high did not set flag seven");

  property p_force_lo;
    flo[0] && !fhi[0] |=> !flg_q[4];
  endproperty
  a_force_lo: assert property (p_force_lo) // RULE10
    else $error("force-low did not clear flag four");

  property p_mask;
    go_next && run_q && ready && flg_q[FLG_I] && !int_f[0] |=> state_q == ST_FETCH;
  endproperty
  a_mask: assert property (p_mask) // RULE11
    else $error("masked interrupt was taken");

  property p_nz;
    ready && ex && flag_we |=> flg_q[FLG_N] == $past(alu_r[7])
      && flg_q[FLG_Z] == ($past(alu_r[7:0]) == 8'h00);
  endproperty
  a_nz: assert property (p_nz) // RULE12
    else $error("negative or zero flag wrong");

  property p_sub_c;
    ready && ex && cls == CLS_SUB |=> flg_q[FLG_C] == ($past(rf_bus.rdata_a) >= $past(opb));
  endproperty
  a_sub_c: assert property (p_sub_c) // RULE13
    else $error("carry is not the inverse of borrow");

  property p_bank;
    rf_bus.idx_a[3] == flg_q[FLG_I] && rf_bus.idx_b[3] == flg_q[FLG_I];
  endproperty
  a_bank: assert property (p_bank) // RULE19
    else $error("bank select does not follow mask bit");

  property p_rd;
    read_strobe |-> op_fetch || (ex && cls == CLS_LD && rf_bus.we == ready);
  endproperty
  a_rd: assert property (p_rd) // RULE22
    else $error("read strobe outside a load");

  c_store: cover property (write_strobe);
  c_load: cover property (ex && cls == CLS_LD && done && ready);
  c_irq: cover property (go_next && run_q && ready && int_pend);
  c_freeze: cover property (!ready ##1 ready);
endmodule

/* rtl/r8dp_pkg.sv */
// shared constants and types of the 8-bit processor datapath
package r8dp_pkg;
  // ==========================================================
  // register bus map, byte addresses
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_STAT = 4'h4;
  localparam logic [3:0] OFF_TEMP = 4'h8;
  localparam int CTRL_RUN_BIT = 0;
  localparam logic CTRL_RUN_RST = 1'b1;
  localparam logic [7:0] TEMP_RST = 8'h00;

  // ==========================================================
  // status flags layout and reset value
  localparam int FLG_I = 3;
  localparam int FLG_N = 2;
  localparam int FLG_C = 1;
  localparam int FLG_Z = 0;
  localparam logic [7:0] FLG_RST = 8'h08;

  // ==========================================================
  // register file shape
  localparam int RF_DEPTH = 16;
  localparam int RF_W = 8;
  localparam int RF_AW = 4;

  // ==========================================================
  // opcode classes (upper nibble) and system opcodes
  localparam logic [3:0] CLS_NOP = 4'h0;
  localparam logic [3:0] CLS_MOVA = 4'h1;
  localparam logic [3:0] CLS_MOVR = 4'h2;
  localparam logic [3:0] CLS_ADD = 4'h3;
  localparam logic [3:0] CLS_SUB = 4'h4;
  localparam logic [3:0] CLS_AND = 4'h5;
  localparam logic [3:0] CLS_OR = 4'h6;
  localparam logic [3:0] CLS_XOR = 4'h7;
  localparam logic [3:0] CLS_INC = 4'h8;
  localparam logic [3:0] CLS_DEC = 4'h9;
  localparam logic [3:0] CLS_BTST = 4'hA;
  localparam logic [3:0] CLS_BSET = 4'hB;
  localparam logic [3:0] CLS_BCLR = 4'hC;
  localparam logic [3:0] CLS_LD = 4'hD;
  localparam logic [3:0] CLS_ST = 4'hE;
  localparam logic [3:0] CLS_SYS = 4'hF;
  localparam logic [7:0] OP_INT = 8'hF0;
  localparam logic [7:0] OP_RTI = 8'hF1;
  localparam logic [7:0] OP_ADDT = 8'hF2;
  localparam logic [7:0] OP_MOVP = 8'hF3;
  localparam logic [7:0] OP_CLRA = 8'hF4;

  // ==========================================================
  // sequencing constants
  localparam logic [3:0] KIND_RST = 4'h8;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [15:0] VEC_BASE = 16'hFFF0;
  localparam logic [1:0] CYC_LAST_LD = 2'h1;
  localparam logic [1:0] CYC_LAST_ST = 2'h2;
  localparam logic READY_RST = 1'b1;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FETCH = 3'b010,
    ST_EXEC = 3'b100
  } r8dp_state_t;

  typedef enum logic [2:0] {
    ALU_PASS, ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR
  } r8dp_alu_t;
endpackage

/* rtl/r8dp_regfile.sv */
// two-bank register file, port a read/write, port b read only
module r8dp_regfile #(
  parameter int DEPTH = r8dp_pkg::RF_DEPTH
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // core side
  r8dp_rf_if.rf rfp
);
  import r8dp_pkg::*;

  if (DEPTH != RF_DEPTH) begin : g_chk
    $error("register file depth must match the index width");
  end

  logic [RF_W-1:0] mem_q [DEPTH];

  // RULE16: one read/write port
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (rfp.we) begin
      mem_q[rfp.idx_a] <= rfp.wdata;
    end
  end

  // RULE15: two simultaneous reads
  assign rfp.rdata_a = mem_q[rfp.idx_a];
  assign rfp.rdata_b = mem_q[rfp.idx_b];

  property p_rf_write;
    @(posedge clk_sys) disable iff (!rst_n)
    rfp.we |=> mem_q[$past(rfp.idx_a)] == $past(rfp.wdata);
  endproperty
  a_rf_write: assert property (p_rf_write) // RULE16
    else $error("register file write was not stored");
endmodule

/* rtl/r8dp_rf_if.sv */
// link between the core and its register file
interface r8dp_rf_if;
  import r8dp_pkg::*;
  logic [RF_AW-1:0] idx_a;
  logic [RF_AW-1:0] idx_b;
  logic we;
  logic [RF_W-1:0] wdata;
  logic [RF_W-1:0] rdata_a;
  logic [RF_W-1:0] rdata_b;
  modport core (output idx_a, output idx_b, output we, output wdata,
                input rdata_a, input rdata_b);
  modport rf (input idx_a, input idx_b, input we, input wdata,
              output rdata_a, output rdata_b);
endinterface

/* testbench/r8dp_mem_model.sv */
// memory and io partner model for the processor datapath bench
module r8dp_mem_model (
  // clock
  input wire logic clk_sys,
  // processor side
  input wire logic [15:0] mem_addr,
  input wire logic read_strobe,
  input wire logic write_strobe,
  input wire logic [7:0] data_out,
  output logic [7:0] bus_read_byte,
  output logic bus_ready,
  // bench control
  input wire logic stall,
  output int wr_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:65535];
  logic [7:0] last_q;
  // empty memory reads as no-operation opcodes
  initial begin
    wr_cnt = 0;
    last_q = 8'h00;
    foreach (mem[i]) mem[i] = 8'h00;
  end
  // released bus shows the inverse of the last byte so stale data never matches
  assign bus_read_byte = read_strobe ? mem[mem_addr] : ~last_q;
  // ready low only while the bench asks for a stall
  assign bus_ready = ~stall;
  // store on the strobe; a strobe held by a freeze only repeats the same byte
  always @(posedge clk_sys) begin
    if (read_strobe) last_q <= mem[mem_addr];
    if (write_strobe) begin
      mem[mem_addr] <= data_out;
      wr_cnt <= wr_cnt + 1;
    end
  end
endmodule

/* testbench/tb_r8dp_core.sv */
// self-checking bench for the 8-bit processor datapath core
module tb_r8dp_core;
  timeunit 1ns;
  timeprecision 1ps;
  import r8dp_pkg::*;
  // ==========================================================
  // signals
  logic clk_sys, arst_n, avs_read, avs_write, read_strobe, write_strobe, op_fetch;
  logic avs_waitrequest, bus_ready, stall, ok;
  logic [3:0] avs_address, avs_byteenable, ffh, ffl, h1, h2, l2;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [15:0] mem_addr, a;
  logic [7:0] bus_read_byte, data_out, int_req, psf, sum, bc, fl;
  int wr_cnt, fail_count, total_checks, seed, w0, k;
  logic [7:0] prog [16] = '{8'hF4, 8'hF2, 8'h24, 8'h25, 8'hD0, 8'h21, 8'h85, 8'hD0,
                            8'h31, 8'hE0, 8'h85, 8'hC0, 8'hE0, 8'h85, 8'h41, 8'hE0};

  r8dp_core #(.NUM_INT(8)) r8dp_core_i (
    .clk_sys(clk_sys), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mem_addr(mem_addr),
    .bus_read_byte(bus_read_byte), .data_out(data_out), .read_strobe(read_strobe),
    .write_strobe(write_strobe), .op_fetch(op_fetch), .bus_ready(bus_ready),
    .int_req(int_req), .flag_force_high(ffh), .flag_force_low(ffl),
    .processor_status_flags(psf));

  r8dp_mem_model r8dp_mem_model_i (
    .clk_sys(clk_sys), .mem_addr(mem_addr), .read_strobe(read_strobe),
    .write_strobe(write_strobe), .data_out(data_out), .bus_read_byte(bus_read_byte),
    .bus_ready(bus_ready), .stall(stall), .wr_cnt(wr_cnt));

  // ==========================================================
  // clock, 8 ns period
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // reporting
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // a wait that ran out ends the run
  task automatic need(input string name, input logic found);
    chk(name, 32'h1, {31'h0, found});
    if (found !== 1'b1) summarize();
  endtask

  // avalon access: hold the request until waitrequest is sampled low
  task automatic av(input logic wr, input logic [3:0] ad, input logic [31:0] wd,
                    input logic [3:0] be);
    int n;
    n = 0;
    // one edge between transfers so no request line is assigned twice in a step
    @(posedge clk_sys);
    avs_address <= ad;
    avs_writedata <= wd;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    need("avs_answer", n < 50);
  endtask

  // flags after the final subtract of the program, mask set by reset entry
  function automatic logic [7:0] exp_flags(input logic [7:0] c, input logic [7:0] x);
    logic [7:0] r;
    r = c - x;
    return {4'h0, 1'b1, r[7], c >= x, r == 8'h00};
  endfunction

  // ==========================================================
  // one program run: load, add, clear bit, subtract, store each result
  task automatic run_case(input logic [7:0] x, input logic [7:0] y, input logic [2:0] bn);
    foreach (prog[i]) r8dp_mem_model_i.mem[16+i] = prog[i];
    r8dp_mem_model_i.mem[27] = 8'hC0 | {5'h00, bn};
    r8dp_mem_model_i.mem[16'h8080] = x;
    r8dp_mem_model_i.mem[16'h8081] = y;
    r8dp_mem_model_i.mem[16'h8082] = 8'hA5;
    r8dp_mem_model_i.mem[16'h8083] = 8'hA5;
    sum = x + y;
    bc = sum & ~(8'h01 << bn);
    fl = exp_flags(bc, x);
    w0 = wr_cnt;
    arst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    ok = 1'b0;
    for (k = 0; k < 20 && !ok; k++) begin
      @(posedge clk_sys);
      ok = (op_fetch === 1'b1);
    end
    need("first_fetch", ok);
    chk("first_fetch_addr", 32'h0, {16'h0, mem_addr});
    av(1'b0, OFF_TEMP, 32'h0, 4'hF);
    chk("temp_reset", {24'h0, TEMP_RST}, rd);
    av(1'b0, OFF_CTRL, 32'h0, 4'hF);
    chk("ctrl_reset", {31'h0, CTRL_RUN_RST}, rd);
    av(1'b0, 4'hC, 32'h0, 4'hF);
    chk("unmapped_read", 32'h0, rd);
    av(1'b1, 4'hC, 32'hFF, 4'hF);
    av(1'b1, OFF_TEMP, 32'h80, 4'h1);
    av(1'b1, OFF_TEMP, 32'h55, 4'hE);
    av(1'b0, OFF_TEMP, 32'h0, 4'hF);
    chk("temp_write", 32'h80, rd);
    for (k = 0; k < 400 && wr_cnt < w0 + 3; k++) @(posedge clk_sys);
    need("program_done", wr_cnt >= w0 + 3);
    chk("sum_store", {24'h0, sum}, {24'h0, r8dp_mem_model_i.mem[16'h8081]});
    chk("bitclr_store", {24'h0, bc}, {24'h0, r8dp_mem_model_i.mem[16'h8082]});
    chk("sub_store", {24'h0, bc - x}, {24'h0, r8dp_mem_model_i.mem[16'h8083]});
    chk("flags_after_sub", {24'h0, fl}, {24'h0, psf});
    av(1'b0, OFF_STAT, 32'h0, 4'hF);
    chk("stat_flags", {24'h0, fl}, {24'h0, rd[7:0]});
    chk("stat_ready", 32'h1, {31'h0, rd[23]});
    // freeze: the address must hold while ready is low
    stall <= 1'b1;
    repeat (5) @(posedge clk_sys);
    a = mem_addr;
    ok = 1'b1;
    repeat (8) begin
      @(posedge clk_sys);
      if (mem_addr !== a) ok = 1'b0;
    end
    chk("frozen_addr", 32'h1, {31'h0, ok});
    stall <= 1'b0;
    // external flag forces, set winning over clear
    h1 = 4'($random(seed));
    h2 = 4'($random(seed));
    l2 = 4'($random(seed));
    ffh <= h1;
    repeat (6) @(posedge clk_sys);
    chk("force_high", {24'h0, h1, fl[3:0]}, {24'h0, psf});
    ffh <= h2;
    ffl <= l2;
    repeat (6) @(posedge clk_sys);
    chk("force_both", {24'h0, (h1 & ~l2) | h2, fl[3:0]}, {24'h0, psf});
    ffh <= 4'h0;
    ffl <= 4'hF;
    repeat (6) @(posedge clk_sys);
    chk("force_low", {24'h0, 4'h0, fl[3:0]}, {24'h0, psf});
    ffl <= 4'h0;
    // masked line one ignored while the mask bit is set, so its vector is never addressed
    int_req <= 8'h02;
    ok = 1'b0;
    repeat (15) begin
      @(posedge clk_sys);
      if (mem_addr === 16'hFFF2) ok = 1'b1;
    end
    chk("masked_line", 32'h0, {31'h0, ok});
    // level line re-enters while held, so pulse it and then look for the vector
    int_req <= 8'h01;
    repeat (3) @(posedge clk_sys);
    int_req <= 8'h00;
    ok = 1'b0;
    for (k = 0; k < 30 && !ok; k++) begin
      @(posedge clk_sys);
      ok = (mem_addr === 16'hFFF0);
    end
    need("nmi_vector", ok);
    chk("nmi_mask_bit", 32'h1, {31'h0, psf[FLG_I]});
  endtask

  // ==========================================================
  // main sequence: corners first, then random operands
  initial begin
    seed = 80370;
    fail_count = 0;
    total_checks = 0;
    arst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    stall = 1'b0;
    int_req = 8'h00;
    ffh = 4'h0;
    ffl = 4'h0;
    repeat (2) @(posedge clk_sys);
    run_case(8'h00, 8'h00, 3'h0);
    run_case(8'hFF, 8'h01, 3'h7);
    run_case(8'h80, 8'h80, 3'h3);
    repeat (6) run_case(8'($random(seed)), 8'($random(seed)), 3'($random(seed)));
    summarize();
  end
endmodule
